// File: logic/nand_host.sv
// APB-controlled host that issues status, identify, reset and read-pointer commands to a NAND flash
// How it works
// - device stays in status mode; host reissues read command before sequential data
// - multi-plane operations are polled with 71h, device returns per-plane results
// - host uses multi-plane pass/fail bits only once ready is reported
// - bits 1-4 are plane results under 71h only; host ignores them and bit 5 otherwise
// - identify is 90h, one zero address, then four bytes read out
// - fourth identify byte C0h means multi-plane; third byte is don't-care
// - host waits at least 10 us recovery after power before any command
// - host holds write-protect low through recovery and while the enable bit is clear; nothing senses power-down
// - program and erase start only after setup then confirm
`timescale 1ns/1ps
`include "nand_host_consts.svh"
module nand_host (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire nand_host_pkg::pins_in_type NAND_IN,
  output nand_host_pkg::pins_out_type NAND_OUT
);

  nand_host_pkg::pins_in_type pin_sync;
  nand_host_pkg::state_type state_q;
  nand_host_pkg::state_type state_d;
  nand_host_pkg::op_type op_q;
  nand_host_pkg::op_type req_op;
  nand_host_pkg::mode_type mode_q;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [1:0] byte_q;
  logic [1:0] byte_d;
  logic cnt_end;
  logic hold_poll;
  logic capture;
  logic [8:0] recov_q;
  logic recov_done;
  logic wren_q;
  logic refused_q;
  logic multi_q;
  logic [7:0] opstat_q;
  logic [31:0] ident_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic apb_wr;
  logic apb_setup;
  logic start;

  function automatic logic [3:0] phase_len(input nand_host_pkg::state_type s);
    case (s)
      nand_host_pkg::ST_RD_LO: phase_len = 4'(`NH_RD_LOW_CYC);
      nand_host_pkg::ST_WAIT_WB: phase_len = 4'(`NH_WB_CYC);
      default: phase_len = 4'(`NH_STROBE_CYC);
    endcase
  endfunction : phase_len

  function automatic logic [7:0] cmd_code(input nand_host_pkg::op_type op);
    case (op)
      nand_host_pkg::OP_STATUS: cmd_code = `NH_CODE_STATUS;
      nand_host_pkg::OP_MSTATUS: cmd_code = `NH_CODE_MSTATUS;
      nand_host_pkg::OP_IDENT: cmd_code = `NH_CODE_IDENT;
      nand_host_pkg::OP_RESET: cmd_code = `NH_CODE_RESET;
      default: cmd_code = `NH_CODE_READ;
    endcase
  endfunction : cmd_code

  // ready/busy is open-drain on the board; the pull-up lives outside
  nand_sync2 #(
    .WIDTH(9)
  ) u_sync (
    .clk(CLOCK),
    .rst_n(RESETN),
    .d(NAND_IN),
    .q(pin_sync)
  );

  assign apb_setup = PSEL && !PENABLE;
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign req_op = nand_host_pkg::op_type'(PWDATA[2:0]);

  // identify and read need the device ready; status and reset do not; other codes never start
  assign start = apb_wr && (PADDR == `NH_ADDR_CMD) && (state_q == nand_host_pkg::ST_IDLE) && recov_done &&
    (req_op == nand_host_pkg::OP_STATUS || req_op == nand_host_pkg::OP_MSTATUS ||
     req_op == nand_host_pkg::OP_RESET ||
     (pin_sync.dev_ready && (req_op == nand_host_pkg::OP_IDENT || req_op == nand_host_pkg::OP_READ)));

  // power-valid proxy: count from reset release before any command
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      recov_q <= 9'h000;
    end else if (!recov_done) begin
      recov_q <= recov_q + 9'h001;
    end
  end
  assign recov_done = (recov_q == 9'(`NH_RECOVERY_CYC));

  assign cnt_end = (cnt_q == phase_len(state_q) - 4'h1);
  // multi-plane poll keeps the strobe low; the device updates the byte live
  assign hold_poll = (op_q == nand_host_pkg::OP_MSTATUS) && !pin_sync.io_in[`NH_IO_READY_BIT];
  assign capture = (state_q == nand_host_pkg::ST_RD_LO) && cnt_end && !hold_poll;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_end ? 4'h0 : cnt_q + 4'h1;
    byte_d = byte_q;
    case (state_q)
      nand_host_pkg::ST_IDLE: begin
        cnt_d = 4'h0;
        byte_d = 2'b00;
        if (start) begin
          state_d = nand_host_pkg::ST_CMD_LO;
        end
      end
      nand_host_pkg::ST_CMD_LO: begin
        if (cnt_end) begin
          state_d = nand_host_pkg::ST_CMD_HI;
        end
      end
      nand_host_pkg::ST_CMD_HI: begin
        if (cnt_end) begin
          case (op_q)
            nand_host_pkg::OP_IDENT: state_d = nand_host_pkg::ST_ADR_LO;
            nand_host_pkg::OP_RESET: state_d = nand_host_pkg::ST_WAIT_WB;
            nand_host_pkg::OP_STATUS: state_d = nand_host_pkg::ST_RD_LO;
            nand_host_pkg::OP_MSTATUS: state_d = nand_host_pkg::ST_RD_LO;
            default: state_d = nand_host_pkg::ST_IDLE;
          endcase
        end
      end
      nand_host_pkg::ST_ADR_LO: begin
        if (cnt_end) begin
          state_d = nand_host_pkg::ST_ADR_HI;
        end
      end
      nand_host_pkg::ST_ADR_HI: begin
        if (cnt_end) begin
          state_d = nand_host_pkg::ST_RD_LO;
        end
      end
      nand_host_pkg::ST_RD_LO: begin
        if (cnt_end && hold_poll) begin
          cnt_d = cnt_q;
        end else if (cnt_end) begin
          state_d = nand_host_pkg::ST_RD_HI;
        end
      end
      nand_host_pkg::ST_RD_HI: begin
        if (cnt_end) begin
          if (op_q == nand_host_pkg::OP_IDENT && byte_q != 2'(`NH_IDENT_BYTES - 1)) begin
            state_d = nand_host_pkg::ST_RD_LO;
            byte_d = byte_q + 2'b01;
          end else begin
            state_d = nand_host_pkg::ST_IDLE;
          end
        end
      end
      nand_host_pkg::ST_WAIT_WB: begin
        if (cnt_end) begin
          state_d = nand_host_pkg::ST_WAIT_RB;
        end
      end
      nand_host_pkg::ST_WAIT_RB: begin
        cnt_d = 4'h0;
        if (pin_sync.dev_ready) begin
          state_d = nand_host_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = nand_host_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= nand_host_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      byte_q <= 2'b00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      byte_q <= byte_d;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      op_q <= nand_host_pkg::OP_NONE;
    end else if (start) begin
      op_q <= req_op;
    end
  end

  // device mode as last commanded, seen from outside
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      mode_q <= nand_host_pkg::MODE_READ;
    end else if (start) begin
      case (req_op)
        nand_host_pkg::OP_STATUS: mode_q <= nand_host_pkg::MODE_STATUS;
        nand_host_pkg::OP_MSTATUS: mode_q <= nand_host_pkg::MODE_STATUS;
        nand_host_pkg::OP_IDENT: mode_q <= nand_host_pkg::MODE_IDENT;
        nand_host_pkg::OP_RESET: mode_q <= nand_host_pkg::MODE_IDLE;
        default: mode_q <= nand_host_pkg::MODE_READ;
      endcase
    end
  end

  // pins are registered from the next state so strobes never glitch
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      NAND_OUT <= '{chip_sel_n: 1'b1, cmd_latch: 1'b0, addr_latch: 1'b0, write_strobe_n: 1'b1,
        read_strobe_n: 1'b1, write_prot_n: 1'b0, io_oe: 1'b0, io_out: 8'h00};
    end else begin
      NAND_OUT.chip_sel_n <= (state_d == nand_host_pkg::ST_IDLE) || (state_d == nand_host_pkg::ST_WAIT_WB) ||
        (state_d == nand_host_pkg::ST_WAIT_RB);
      NAND_OUT.cmd_latch <= (state_d == nand_host_pkg::ST_CMD_LO) || (state_d == nand_host_pkg::ST_CMD_HI);
      NAND_OUT.addr_latch <= (state_d == nand_host_pkg::ST_ADR_LO) || (state_d == nand_host_pkg::ST_ADR_HI);
      NAND_OUT.write_strobe_n <= !((state_d == nand_host_pkg::ST_CMD_LO) || (state_d == nand_host_pkg::ST_ADR_LO));
      NAND_OUT.read_strobe_n <= (state_d != nand_host_pkg::ST_RD_LO);
      NAND_OUT.write_prot_n <= wren_q && recov_done;
      NAND_OUT.io_oe <= (state_d >= nand_host_pkg::ST_CMD_LO) && (state_d <= nand_host_pkg::ST_ADR_HI);
      // op_q is loaded on the start edge itself, so the first command byte comes from the request
      NAND_OUT.io_out <= (state_d == nand_host_pkg::ST_ADR_LO || state_d == nand_host_pkg::ST_ADR_HI) ?
        `NH_IDENT_ADDR : cmd_code(state_q == nand_host_pkg::ST_IDLE ? req_op : op_q);
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      opstat_q <= `NH_OPSTAT_RESET;
      ident_q <= 32'h00000000;
      multi_q <= 1'b0;
    end else if (capture) begin
      case (op_q)
        nand_host_pkg::OP_STATUS: opstat_q <= pin_sync.io_in & `NH_MASK_SINGLE;
        nand_host_pkg::OP_MSTATUS: opstat_q <= pin_sync.io_in & `NH_MASK_MULTI;
        nand_host_pkg::OP_IDENT: begin
          // third byte is stored as zero, its content means nothing
          ident_q[byte_q*8 +: 8] <= (byte_q == 2'b10) ? 8'h00 : pin_sync.io_in;
          if (byte_q == 2'b11) begin
            multi_q <= (pin_sync.io_in == `NH_IDENT_MULTI);
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      wren_q <= 1'(`NH_CTRL_RESET);
    end else if (apb_wr && PADDR == `NH_ADDR_CTRL) begin
      wren_q <= PWDATA[`NH_CTRL_WREN_BIT];
    end
  end

  // every command write rewrites the flag: set if refused, cleared if accepted
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      refused_q <= 1'b0;
    end else if (apb_wr && PADDR == `NH_ADDR_CMD) begin
      refused_q <= !start;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
      if (PADDR == `NH_ADDR_CMD) begin
        prdata_q <= {29'h00000000, op_q};
      end else if (PADDR == `NH_ADDR_CTRL) begin
        prdata_q <= {31'h00000000, wren_q};
      end else if (PADDR == `NH_ADDR_STATUS) begin
        prdata_q[`NH_ST_BUSY_BIT] <= (state_q != nand_host_pkg::ST_IDLE);
        prdata_q[`NH_ST_RECOV_BIT] <= recov_done;
        prdata_q[`NH_ST_READY_BIT] <= pin_sync.dev_ready;
        prdata_q[`NH_ST_REFUSED_BIT] <= refused_q;
        prdata_q[`NH_ST_MULTI_BIT] <= multi_q;
        prdata_q[`NH_ST_MODE_LSB +: 2] <= mode_q;
        prdata_q[`NH_ST_BYTE_LSB +: 8] <= opstat_q;
      end else if (PADDR == `NH_ADDR_ID) begin
        prdata_q <= ident_q;
      end else begin
        pslverr_q <= 1'b1;
      end
    end
  end

  assign PRDATA = prdata_q;
  assign PSLVERR = pslverr_q;
  assign PREADY = 1'b1;

endmodule : nand_host

// File: logic/nand_sync2.sv
// two flip-flop synchroniser for the flash pin inputs
`timescale 1ns/1ps
module nand_sync2 #(
  parameter int WIDTH = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : nand_sync2

// File: shared/nand_host_consts.svh
// timing counts, register offsets, field positions and command codes of the flash host
`ifndef NAND_HOST_CONSTS_SVH
`define NAND_HOST_CONSTS_SVH

`define NH_CLK_MHZ 40
`define NH_T_RECOVERY_NS 10000
`define NH_T_STROBE_NS 50
`define NH_T_WB_NS 100
`define NH_SYNC_CYC 2
`define NH_RECOVERY_CYC ((`NH_T_RECOVERY_NS * `NH_CLK_MHZ + 999) / 1000)
`define NH_STROBE_CYC ((`NH_T_STROBE_NS * `NH_CLK_MHZ + 999) / 1000)
`define NH_WB_CYC ((`NH_T_WB_NS * `NH_CLK_MHZ + 999) / 1000)
`define NH_RD_LOW_CYC (`NH_STROBE_CYC + `NH_SYNC_CYC)

`define NH_ADDR_CMD 8'h00
`define NH_ADDR_CTRL 8'h04
`define NH_ADDR_STATUS 8'h08
`define NH_ADDR_ID 8'h0C

`define NH_CTRL_WREN_BIT 0
`define NH_CTRL_RESET 32'h00000000

`define NH_ST_BUSY_BIT 0
`define NH_ST_RECOV_BIT 1
`define NH_ST_READY_BIT 2
`define NH_ST_REFUSED_BIT 3
`define NH_ST_MULTI_BIT 4
`define NH_ST_MODE_LSB 5
`define NH_ST_BYTE_LSB 8
`define NH_OPSTAT_RESET 8'hC0

`define NH_IO_READY_BIT 6
`define NH_MASK_SINGLE 8'hC1
`define NH_MASK_MULTI 8'hDF

`define NH_CODE_STATUS 8'h70
`define NH_CODE_MSTATUS 8'h71
`define NH_CODE_IDENT 8'h90
`define NH_CODE_RESET 8'hFF
`define NH_CODE_READ 8'h00
`define NH_IDENT_ADDR 8'h00
`define NH_IDENT_MULTI 8'hC0
`define NH_IDENT_BYTES 4

`endif

// File: shared/nand_host_pkg.sv
// types shared by the flash host controller
package nand_host_pkg;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_STATUS = 3'b001,
    OP_MSTATUS = 3'b010,
    OP_IDENT = 3'b011,
    OP_RESET = 3'b100,
    OP_READ = 3'b101
  } op_type;

  typedef enum logic [1:0] {
    MODE_READ = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_STATUS = 2'b10,
    MODE_IDENT = 2'b11
  } mode_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_CMD_LO = 4'b0001,
    ST_CMD_HI = 4'b0010,
    ST_ADR_LO = 4'b0011,
    ST_ADR_HI = 4'b0100,
    ST_RD_LO = 4'b0101,
    ST_RD_HI = 4'b0110,
    ST_WAIT_WB = 4'b0111,
    ST_WAIT_RB = 4'b1000
  } state_type;

  typedef struct packed {
    logic chip_sel_n;
    logic cmd_latch;
    logic addr_latch;
    logic write_strobe_n;
    logic read_strobe_n;
    logic write_prot_n;
    logic io_oe;
    logic [7:0] io_out;
  } pins_out_type;

  typedef struct packed {
    logic dev_ready;
    logic [7:0] io_in;
  } pins_in_type;

endpackage : nand_host_pkg

// File: sim/nand_dev_model.sv
// behavioural flash device on the far side of the host
`timescale 1ns/1ps
module nand_dev_model #(
  parameter logic [7:0] MAKER = 8'h3A,
  parameter logic [7:0] PART = 8'h5C,
  parameter logic [3:0] PLANE_FAIL = 4'h4,
  parameter int RST_NS = 2000
) (
  input wire nand_host_pkg::pins_out_type pins,
  input wire logic op_busy,
  output logic [7:0] io_drv,
  output logic rb_low
);
  logic [1:0] mode = 2'h0;
  logic [1:0] idx = 2'h0;
  logic [3:0] pfail = 4'h0;
  logic rst_busy = 1'b0;
  logic rst_state = 1'b0;
  logic [7:0] val;
  logic [7:0] last = 8'h00;
  wire drive = !pins.chip_sel_n && !pins.read_strobe_n;
  assign rb_low = rst_busy || op_busy;
  always @(posedge pins.write_strobe_n) begin
    if (!pins.chip_sel_n && pins.addr_latch) idx = 2'h0;
    if (!pins.chip_sel_n && pins.cmd_latch) begin
      if (pins.io_out != 8'hFF) rst_state = 1'b0;
      case (pins.io_out)
        8'h70, 8'h71: mode = 2'h2;
        8'h90: if (!rb_low) mode = 2'h3;
        8'h00: if (!rb_low) mode = 2'h0;
        8'hFF: if (!rst_state) begin
          mode = 2'h1;
          pfail = 4'h0;
          rst_busy = 1'b1;
          #(RST_NS) rst_busy = 1'b0;
          rst_state = 1'b1;
        end
        default: ;
      endcase
    end
  end
  always @(posedge pins.read_strobe_n) if (!pins.chip_sel_n && mode == 2'h3) idx = idx + 2'h1;
  always @(negedge op_busy) pfail = PLANE_FAIL;
  // reserved and plane bits stay live so a missing mask shows up
  always_comb begin
    val = {pins.write_prot_n, !rb_low, 1'b1, pfail, |pfail};
    if (mode == 2'h3) val = idx == 2'h0 ? MAKER : idx == 2'h1 ? PART : idx == 2'h2 ? 8'h77 : 8'hC0;
  end
  always @(val or drive) if (drive) last = val;
  assign io_drv = drive ? val : ~last;
endmodule : nand_dev_model

// File: sim/nand_host_properties.sv
// pin-level checks on the flash host controller
`timescale 1ns/1ps
module nand_host_properties (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire nand_host_pkg::pins_out_type NAND_OUT
);
  logic [8:0] rec_q;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rec_q <= 9'h000;
    end else if (rec_q != 9'h190) begin
      rec_q <= rec_q + 9'h001;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  sequence s_ws_low;
    !NAND_OUT.write_strobe_n [*2];
  endsequence
  sequence s_ws_high;
    NAND_OUT.write_strobe_n [*2];
  endsequence
  property p_ws_pulse;
    $fell(NAND_OUT.write_strobe_n) |-> s_ws_low ##1 s_ws_high;
  endproperty
  a_ws_pulse: assert property (p_ws_pulse) else $error("write strobe width");
  property p_rd_min;
    $fell(NAND_OUT.read_strobe_n) |-> !NAND_OUT.read_strobe_n [*4];
  endproperty
  a_rd_min: assert property (p_rd_min) else $error("read strobe too short");
  property p_strobe_cs;
    (!NAND_OUT.write_strobe_n || !NAND_OUT.read_strobe_n) |-> !NAND_OUT.chip_sel_n;
  endproperty
  a_strobe_cs: assert property (p_strobe_cs) else $error("strobe without select");
  property p_no_drive_read;
    !NAND_OUT.read_strobe_n |-> !NAND_OUT.io_oe;
  endproperty
  a_no_drive_read: assert property (p_no_drive_read) else $error("bus fight in read");
  property p_data_stable;
    !NAND_OUT.write_strobe_n |-> NAND_OUT.io_oe ##1 (NAND_OUT.write_strobe_n || $stable(NAND_OUT.io_out));
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved in strobe");
  property p_addr_zero;
    (NAND_OUT.addr_latch && !NAND_OUT.write_strobe_n) |-> NAND_OUT.io_out == 8'h00;
  endproperty
  a_addr_zero: assert property (p_addr_zero) else $error("identify address not zero");
  property p_recov_quiet;
    rec_q < 9'h18F |-> NAND_OUT.chip_sel_n;
  endproperty
  a_recov_quiet: assert property (p_recov_quiet) else $error("select during recovery");
  property p_recov_wp;
    rec_q < 9'h18F |-> !NAND_OUT.write_prot_n;
  endproperty
  a_recov_wp: assert property (p_recov_wp) else $error("protect released early");
  property p_reset_wait;
    ($rose(NAND_OUT.write_strobe_n) && NAND_OUT.cmd_latch && NAND_OUT.io_out == 8'hFF)
      |-> ##[1:3] NAND_OUT.chip_sel_n [*4];
  endproperty
  a_reset_wait: assert property (p_reset_wait) else $error("no wait after reset");
  property p_codes;
    (NAND_OUT.cmd_latch && !NAND_OUT.write_strobe_n)
      |-> NAND_OUT.io_out inside {8'h70, 8'h71, 8'h90, 8'hFF, 8'h00};
  endproperty
  a_codes: assert property (p_codes) else $error("unexpected command code");
endmodule : nand_host_properties

bind nand_host nand_host_properties chk (.CLOCK(CLOCK), .RESETN(RESETN), .NAND_OUT(NAND_OUT));

// File: sim/nand_host_tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`include "nand_host_consts.svh"
module nand_host_tb;
  localparam logic [7:0] MAKER = 8'h3A; // arbitrary value
  localparam logic [7:0] PART = 8'h5C; // arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rq;
  logic err;
  logic op_busy = 1'b0;
  logic rb_low;
  logic [7:0] dev_io;
  nand_host_pkg::pins_out_type nout;
  wire nand_host_pkg::pins_in_type nin = {!rb_low, nout.io_oe ? nout.io_out : dev_io};
  int n_fail = 0;
  int tests_run = 0;
  int rb_falls = 0;
  nand_host uut (.CLOCK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .NAND_IN(nin), .NAND_OUT(nout));
  nand_dev_model #(.MAKER(MAKER), .PART(PART)) dev (.pins(nout), .op_busy(op_busy), .io_drv(dev_io),
    .rb_low(rb_low));
  initial forever #12.5 clk = ~clk;
  always @(posedge rb_low) rb_falls++;
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_fail++;
      final_report();
    end
    rq = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // leaves the last status word in rq
  task automatic poll(input int b, input logic v);
    int i;
    i = 0;
    do begin
      apb(1'b0, `NH_ADDR_STATUS, 32'h0);
      i++;
    end while (rq[b] !== v && i < 500);
    if (i >= 500) begin
      n_fail++;
      final_report();
    end
  endtask : poll
  task automatic run(input logic [2:0] op);
    apb(1'b1, `NH_ADDR_CMD, {29'h0, op});
    poll(0, 1'b0);
  endtask : run
  task automatic t_boot();
    apb(1'b0, `NH_ADDR_STATUS, 32'h0);
    chk(rq & 32'hFFFFFFFB, 32'h0000C000, "boot status");
    apb(1'b0, `NH_ADDR_CTRL, 32'h0);
    chk(rq, 32'h0, "control reset");
    run(3'h1);
    chk(rq[3], 1'b1, "early command");
    apb(1'b0, 8'h10, 32'h0);
    chk({rq[30:0], err}, 32'h1, "unmapped read");
    poll(1, 1'b1);
    chk(nout.write_prot_n, 1'b0, "protect held");
  endtask : t_boot
  task automatic t_busy();
    apb(1'b1, `NH_ADDR_CTRL, 32'h1);
    op_busy <= 1'b1;
    repeat (4) @(posedge clk);
    run(3'h3);
    chk(rq[3:2], 2'b10, "identify while busy");
    apb(1'b1, `NH_ADDR_CMD, 32'h2);
    repeat (40) @(posedge clk);
    apb(1'b0, `NH_ADDR_STATUS, 32'h0);
    chk(rq[0], 1'b1, "poll waits for ready");
    op_busy <= 1'b0;
    poll(0, 1'b0);
    chk(rq[15:8], 8'hC9, "plane results");
    run(3'h1);
    chk(rq[15:8], 8'hC1, "single plane status");
  endtask : t_busy
  task automatic t_ident();
    run(3'h3);
    chk(rq[6:4], 3'h7, "identify mode");
    apb(1'b0, `NH_ADDR_ID, 32'h0);
    chk(rq, {8'hC0, 8'h00, PART, MAKER}, "identify bytes");
    apb(1'b0, `NH_ADDR_CMD, 32'h0);
    chk(rq, 32'h00000003, "last op readback");
  endtask : t_ident
  task automatic t_reset();
    int n;
    n = rb_falls;
    run(3'h4);
    chk(rq[6:5], 2'h1, "mode after reset");
    chk(rb_falls - n, 1, "busy pulse");
    run(3'h4);
    chk(rb_falls - n, 1, "repeat reset");
    apb(1'b1, `NH_ADDR_CTRL, 32'h0);
    run(3'h1);
    chk(rq[15:8], 8'h40, "protected status");
    apb(1'b1, `NH_ADDR_CTRL, 32'h1);
    run(3'h1);
    chk(rq[15:8], 8'hC0, "status after reset");
    chk(rq[6:5], 2'h2, "status mode");
  endtask : t_reset
  task automatic t_read();
    run(3'h5);
    chk(rq[6:5], 2'h0, "read mode");
    for (int c = 6; c < 9; c++) begin
      run(c[2:0]);
      chk(rq[3], 1'b1, "bad op code");
    end
  endtask : t_read
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_boot();
    t_busy();
    t_ident();
    t_reset();
    t_read();
    final_report();
  end
endmodule : nand_host_tb
